/* File: inc/pcs_pkg.sv */
// constants shared by the power control and supply switchover block
// assumes an 8-bit special-function register port driven by the core
//
// What this block does
// - metering shutdown bit powers down metering
// - core shutdown in battery mode enters deep sleep
// - clock divider gives 4.096 MHz over 2^field
// - power control write needs key 0xA7 first
// - source flag bit 6: one on main
// - switchover on by default; bit 1 disables
// - low main supply moves to battery
// - enabled control pin falling edge forces battery
// - return needs every enabled supply condition
// - enabled control pin must also be high
// - metering converters unavailable on battery
// - core keeps running across supply changes
// - supply interrupt off until enable bit set
// - per-event enables select interrupt sources
// - event flags latch; software clears them
// - select field: 00 main, 01 plus dc, 1X off
// - low dc input switches after 30 ms
// - restore waits 130 ms after conditions met
// - switch and restore flags set regardless enables
`default_nettype none
package pcs_pkg;
    // ========================================================
    // register addresses
    localparam logic [7:0] ADDR_IRQ_EN_PRIO2  = 8'hA9;
    localparam logic [7:0] ADDR_WRITE_KEY     = 8'hC1;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'hC5;
    localparam logic [7:0] ADDR_EVENT_ENABLE  = 8'hEC;
    localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'hF4;
    localparam logic [7:0] ADDR_SWITCH_CONFIG = 8'hF5;
    localparam logic [7:0] ADDR_EVENT_FLAG    = 8'hF8;
    localparam logic [7:0] ADDR_INT_PIN_CFG   = 8'hFF;
    localparam logic [7:0] WRITE_KEY_VALUE    = 8'hA7;

    // ========================================================
    // field positions and reset values
    localparam int          PC_METER_OFF_BIT = 6;
    localparam int          PC_CORE_OFF_BIT  = 4;
    localparam logic [7:0]  PC_RESET         = 8'h82;
    localparam logic [7:0]  PC_WRITABLE      = 8'h77;
    localparam logic [7:0]  PC_FORCED_ONES   = 8'h80;
    localparam int          DC_SOURCE_BIT    = 6;
    localparam int          DC_VDD_OK_BIT    = 5;
    localparam int          SC_DISABLE_BIT   = 1;
    localparam int          SC_DCIN_BIT      = 0;
    localparam int          EV_RESTORE_BIT   = 7;
    localparam int          EV_SWITCH_BIT    = 1;
    localparam logic [7:0]  EV_MASK          = 8'h82;
    localparam int          IE2_SUPPLY_BIT   = 1;
    localparam int          INT1_CFG_LSB     = 4;
    localparam logic [1:0]  INT1_BATT_CTRL   = 2'h1;

    // ========================================================
    // timing
    localparam longint MCLK_KHZ          = 125000;
    localparam longint CORE_BASE_KHZ     = 4096;
    localparam longint DCIN_DELAY_MS     = 30;
    localparam longint RESTORE_DELAY_MS  = 130;
    localparam int     DCIN_DELAY_CYC    = int'(DCIN_DELAY_MS * MCLK_KHZ);
    localparam int     RESTORE_DELAY_CYC = int'(RESTORE_DELAY_MS * MCLK_KHZ);
    localparam logic [31:0] CORE_PHASE_INC =
        32'((CORE_BASE_KHZ << 32) / MCLK_KHZ);

    typedef enum logic [1:0] {
        SUP_ON_MAIN = 2'b00,
        SUP_ON_BATT = 2'b01
    } pcs_supply_t;
endpackage : pcs_pkg
`default_nettype wire

/* File: logic/pcs_clk_div.sv */
// core clock enable generator: phase accumulator with power-of-two divide
// assumes a single free-running master clock
`timescale 1ns/1ns
`default_nettype none
module pcs_clk_div (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // divide select
    input  wire logic [2:0]  i_div_sel,
    // core clock enable
    output logic             o_core_en
);
    import pcs_pkg::*;

    logic [32:0] acc_ff;
    logic [32:0] nxt_acc;

    // fractional step keeps the long-term rate exact at non-integer ratios
    assign nxt_acc = {1'b0, acc_ff[31:0]} + {1'b0, CORE_PHASE_INC >> i_div_sel};

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            acc_ff <= 33'h0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    assign o_core_en = acc_ff[32];
endmodule : pcs_clk_div
`default_nettype wire

/* File: logic/pcs_delay_timer.sv */
// qualification timer: done once run has held for LIMIT cycles
// assumes run is a level synchronous to the master clock
`timescale 1ns/1ns
`default_nettype none
module pcs_delay_timer #(
    parameter int LIMIT = 16
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_run,
    output logic      o_done
);
    localparam int          CW  = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] TOP = CW'(LIMIT);

    logic [CW-1:0] cnt_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !i_run) begin
            cnt_ff <= '0;
        end else if (cnt_ff != TOP) begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    assign o_done = i_run && (cnt_ff == TOP);
endmodule : pcs_delay_timer
`default_nettype wire

/* File: logic/pcs_power_ctrl.sv */
// power control register, supply switchover and supply event logic
// assumes comparator results and control pin synchronous to i_mclk
`timescale 1ns/1ns
`default_nettype none
module pcs_power_ctrl #(
    parameter int DCIN_DELAY    = pcs_pkg::DCIN_DELAY_CYC,
    parameter int RESTORE_DELAY = pcs_pkg::RESTORE_DELAY_CYC
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // special-function register port
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic      [7:0]  o_sfr_rdata,
    // supply supervision
    input  wire logic        i_vdd_ok,
    input  wire logic        i_dcin_ok,
    input  wire logic        i_batt_ctrl_pin,
    // power controls
    output logic             o_supply_on_main,
    output logic             o_meter_off,
    output logic             o_meter_adc_avail,
    output logic             o_core_en,
    output logic             o_core_run,
    output logic             o_deep_sleep,
    output logic             o_supply_irq
);
    import pcs_pkg::*;

    // ========================================================
    // registers
    logic [7:0]  pc_ff;
    logic        key_armed_ff;
    logic [1:0]  sw_cfg_ff;
    logic [1:0]  int1_cfg_ff;
    logic [7:0]  ev_en_ff;
    logic [7:0]  ev_flag_ff;
    logic        irq_en_ff;
    logic        deep_ff;
    logic        pin_ff;
    logic [7:0]  rdata_ff;
    pcs_supply_t sup_ff;
    pcs_supply_t nxt_sup;

    logic pc_wr_ok;
    logic sw_disabled;
    logic dcin_sel;
    logic pin_en;
    logic pin_fall;
    logic dcin_low_done;
    logic restore_cond;
    logic restore_done;
    logic to_batt;
    logic to_main;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = i_sfr_wr && (i_sfr_addr == a);
    endfunction : wr_at

    // ========================================================
    // key and power control
    assign pc_wr_ok = wr_at(ADDR_POWER_CONTROL) && key_armed_ff;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            key_armed_ff <= 1'b0;
        end else if (i_sfr_wr) begin
            // any write consumes the key
            key_armed_ff <= wr_at(ADDR_WRITE_KEY) && (i_sfr_wdata == WRITE_KEY_VALUE);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pc_ff <= PC_RESET;
        end else if (pc_wr_ok) begin
            // bit 5 is stored as written; software is expected to keep it zero
            pc_ff <= (i_sfr_wdata & PC_WRITABLE) | PC_FORCED_ONES;
        end
    end

    // shutdown only honoured on battery; it ends on the edge main returns,
    // so a shutdown racing a restore never stops the core for one cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            deep_ff <= 1'b0;
        end else if (nxt_sup == SUP_ON_MAIN) begin
            deep_ff <= 1'b0;
        end else if (pc_wr_ok && i_sfr_wdata[PC_CORE_OFF_BIT] && sup_ff == SUP_ON_BATT) begin
            deep_ff <= 1'b1;
        end
    end

    // ========================================================
    // configuration registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sw_cfg_ff <= 2'h0;
        end else if (wr_at(ADDR_SWITCH_CONFIG)) begin
            sw_cfg_ff <= i_sfr_wdata[1:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            int1_cfg_ff <= 2'h0;
        end else if (wr_at(ADDR_INT_PIN_CFG)) begin
            int1_cfg_ff <= i_sfr_wdata[INT1_CFG_LSB +: 2];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ev_en_ff <= 8'h00;
        end else if (wr_at(ADDR_EVENT_ENABLE)) begin
            ev_en_ff <= i_sfr_wdata & EV_MASK;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            irq_en_ff <= 1'b0;
        end else if (wr_at(ADDR_IRQ_EN_PRIO2)) begin
            irq_en_ff <= i_sfr_wdata[IE2_SUPPLY_BIT];
        end
    end

    // ========================================================
    // switchover decision
    assign sw_disabled = sw_cfg_ff[SC_DISABLE_BIT];
    assign dcin_sel    = !sw_disabled && sw_cfg_ff[SC_DCIN_BIT];
    assign pin_en      = (int1_cfg_ff == INT1_BATT_CTRL);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_ff <= 1'b1;
        end else begin
            pin_ff <= i_batt_ctrl_pin;
        end
    end

    assign pin_fall = pin_en && pin_ff && !i_batt_ctrl_pin;

    pcs_delay_timer #(
        .LIMIT (DCIN_DELAY)
    ) u_dcin_timer (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (sup_ff == SUP_ON_MAIN && dcin_sel && !i_dcin_ok),
        .o_done  (dcin_low_done)
    );

    assign restore_cond = i_vdd_ok
                       && (!dcin_sel || i_dcin_ok)
                       && (!pin_en || i_batt_ctrl_pin);

    pcs_delay_timer #(
        .LIMIT (RESTORE_DELAY)
    ) u_restore_timer (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_run   (sup_ff == SUP_ON_BATT && restore_cond),
        .o_done  (restore_done)
    );

    // the control pin acts even with level switchover disabled
    assign to_batt = (!sw_disabled && !i_vdd_ok)
                  || dcin_low_done
                  || pin_fall;

    always_comb begin
        nxt_sup = sup_ff;
        case (sup_ff)
            SUP_ON_MAIN: begin
                if (to_batt) begin
                    nxt_sup = SUP_ON_BATT;
                end
            end
            SUP_ON_BATT: begin
                if ((sw_disabled && !pin_en) || restore_done) begin
                    nxt_sup = SUP_ON_MAIN;
                end
            end
            default: begin
                nxt_sup = SUP_ON_MAIN;
            end
        endcase
    end

    assign to_main = (sup_ff == SUP_ON_BATT) && (nxt_sup == SUP_ON_MAIN);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sup_ff <= SUP_ON_MAIN;
        end else begin
            sup_ff <= nxt_sup;
        end
    end

    // ========================================================
    // supply events
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ev_flag_ff <= 8'h00;
        end else begin
            // write zero clears; a same-cycle event still sets
            if (wr_at(ADDR_EVENT_FLAG)) begin
                ev_flag_ff <= ev_flag_ff & i_sfr_wdata & EV_MASK;
            end
            if (sup_ff == SUP_ON_MAIN && nxt_sup == SUP_ON_BATT) begin
                ev_flag_ff[EV_SWITCH_BIT] <= 1'b1;
            end
            if (to_main) begin
                ev_flag_ff[EV_RESTORE_BIT] <= 1'b1;
            end
        end
    end

    assign o_supply_irq = irq_en_ff && |(ev_flag_ff & ev_en_ff);

    // ========================================================
    // power outputs
    pcs_clk_div u_clk_div (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_div_sel (pc_ff[2:0]),
        .o_core_en (o_core_en)
    );

    assign o_supply_on_main  = (sup_ff == SUP_ON_MAIN);
    assign o_meter_off       = pc_ff[PC_METER_OFF_BIT];
    assign o_meter_adc_avail = o_supply_on_main && !o_meter_off;
    assign o_core_run        = !deep_ff;
    assign o_deep_sleep      = deep_ff;

    // ========================================================
    // read port
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rdata_ff <= 8'h00;
        end else if (i_sfr_rd) begin
            case (i_sfr_addr)
                ADDR_POWER_CONTROL: rdata_ff <= pc_ff;
                ADDR_SWITCH_CONFIG: rdata_ff <= {6'h00, sw_cfg_ff};
                ADDR_INT_PIN_CFG:   rdata_ff <= 8'(int1_cfg_ff) << INT1_CFG_LSB;
                ADDR_EVENT_ENABLE:  rdata_ff <= ev_en_ff;
                ADDR_EVENT_FLAG:    rdata_ff <= ev_flag_ff;
                ADDR_IRQ_EN_PRIO2:  rdata_ff <= 8'(irq_en_ff) << IE2_SUPPLY_BIT;
                ADDR_DEVICE_CONFIG: begin
                    rdata_ff <= 8'h00;
                    rdata_ff[DC_SOURCE_BIT] <= o_supply_on_main;
                    rdata_ff[DC_VDD_OK_BIT] <= i_vdd_ok;
                end
                default:            rdata_ff <= 8'h00;
            endcase
        end
    end

    assign o_sfr_rdata = rdata_ff;

    // ========================================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    AST_KEY_REQUIRED: assert property (
        wr_at(ADDR_POWER_CONTROL) && !key_armed_ff |=> $stable(pc_ff))
        else $error("power control changed without key");
    AST_KEY_ONESHOT: assert property (
        i_sfr_wr && !wr_at(ADDR_WRITE_KEY) |=> !key_armed_ff)
        else $error("key still armed after a write");
    AST_SOURCE_READ: assert property (
        i_sfr_rd && i_sfr_addr == ADDR_DEVICE_CONFIG
        |=> o_sfr_rdata[DC_SOURCE_BIT] == $past(o_supply_on_main))
        else $error("source flag read mismatch");
    AST_LOW_VDD_SWITCH: assert property (
        o_supply_on_main && !sw_disabled && !i_vdd_ok |=> !o_supply_on_main)
        else $error("no switch on low main supply");
    AST_DISABLED_MAIN: assert property (
        sw_disabled && !pin_en ##1 sw_disabled && !pin_en |-> o_supply_on_main)
        else $error("battery used while switchover disabled");
    AST_PIN_SWITCH: assert property (
        o_supply_on_main && pin_en && $fell(i_batt_ctrl_pin) |=> !o_supply_on_main)
        else $error("control pin edge ignored");
    AST_ADC_OFF_BATT: assert property (
        !o_supply_on_main |-> !o_meter_adc_avail)
        else $error("metering converters on battery");
    AST_SWITCH_FLAG: assert property (
        $fell(o_supply_on_main) |-> ev_flag_ff[EV_SWITCH_BIT])
        else $error("switch flag missing");
    AST_RESTORE_FLAG: assert property (
        $rose(o_supply_on_main) |-> ev_flag_ff[EV_RESTORE_BIT])
        else $error("restore flag missing");
    AST_IRQ_GATED: assert property (
        o_supply_irq |-> irq_en_ff
            && (ev_flag_ff[EV_SWITCH_BIT] && ev_en_ff[EV_SWITCH_BIT]
                || ev_flag_ff[EV_RESTORE_BIT] && ev_en_ff[EV_RESTORE_BIT]))
        else $error("interrupt without enable");
    AST_RESTORE_IRQ: assert property (
        irq_en_ff && ev_en_ff[EV_RESTORE_BIT] && $rose(o_supply_on_main) |-> o_supply_irq)
        else $error("enabled restore event gave no interrupt");
    AST_RUN_THROUGH: assert property (
        $changed(o_supply_on_main) && !$past(deep_ff) |-> o_core_run)
        else $error("core stopped by supply change");
    AST_NO_EARLY_RESTORE: assert property (
        !o_supply_on_main && !restore_cond && !sw_disabled |=> !o_supply_on_main)
        else $error("restore without conditions");

    COV_SWITCH:  cover property (o_supply_on_main ##1 !o_supply_on_main);
    COV_RESTORE: cover property (!o_supply_on_main ##1 o_supply_on_main);
    COV_DEEP:    cover property ($rose(deep_ff));
    COV_IRQ:     cover property ($rose(o_supply_irq));
endmodule : pcs_power_ctrl
`default_nettype wire

/* File: dv/pcs_supply_model.sv */
// supply supervision model: main and dc comparators plus battery control pin
// assumes the bench sets the wanted levels; outputs move on the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module pcs_supply_model (
    // clock
    input  wire logic i_mclk,
    // wanted levels
    input  wire logic i_vdd_good,
    input  wire logic i_dcin_good,
    input  wire logic i_pin_high,
    // comparator results and pin
    output logic      o_vdd_ok,
    output logic      o_dcin_ok,
    output logic      o_batt_ctrl_pin
);
    // ==========================================================
    // comparators
    // registered so a level change lands one cycle late, like a real comparator
    initial begin
        o_vdd_ok        = 1'b1;
        o_dcin_ok       = 1'b1;
        o_batt_ctrl_pin = 1'b1;
    end
    always @(negedge i_mclk) begin
        o_vdd_ok        <= i_vdd_good;
        o_dcin_ok       <= i_dcin_good;
        o_batt_ctrl_pin <= i_pin_high;
    end
endmodule : pcs_supply_model
`default_nettype wire

/* File: dv/power_control_battery_switchover_tb.sv */
// bench for the power control and supply switchover block
// assumes short qualification delays; the supply model stands in for the board
`timescale 1ns/1ns
`default_nettype none
module power_control_battery_switchover_tb;
    import pcs_pkg::*;
    localparam int DD = 8;
    localparam int RD = 20;
    // ==========================================================
    // stimulus and observation
    logic       i_mclk    = 1'b0;
    logic       i_rst_n   = 1'b0;
    logic [7:0] sfr_addr  = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic       sfr_rd    = 1'b0;
    logic       vdd       = 1'b1;
    logic       dcin      = 1'b1;
    logic       pin       = 1'b1;
    logic       vdd_ok, dcin_ok, bpin;
    logic [7:0] rdata;
    logic       on_main, meter_off, adc_ok, core_en, core_run, deep, irq;
    int         n_errors  = 0;
    int         tests_run = 0;
    int         n;

    always #4 i_mclk = ~i_mclk;

    pcs_supply_model u_pcs_supply_model (
        .i_mclk(i_mclk), .i_vdd_good(vdd), .i_dcin_good(dcin), .i_pin_high(pin),
        .o_vdd_ok(vdd_ok), .o_dcin_ok(dcin_ok), .o_batt_ctrl_pin(bpin)
    );

    pcs_power_ctrl #(.DCIN_DELAY(DD), .RESTORE_DELAY(RD)) u_pcs_power_ctrl (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr),
        .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata),
        .i_vdd_ok(vdd_ok), .i_dcin_ok(dcin_ok), .i_batt_ctrl_pin(bpin),
        .o_supply_on_main(on_main), .o_meter_off(meter_off), .o_meter_adc_avail(adc_ok),
        .o_core_en(core_en), .o_core_run(core_run), .o_deep_sleep(deep), .o_supply_irq(irq)
    );

    // ==========================================================
    // access and compare tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic check_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : check_range

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge i_mclk);
        sfr_wr    = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_mclk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge i_mclk);
        sfr_rd   = 1'b0;
        check(rdata, exp);
    endtask : rd_chk

    // key must come directly before the protected write
    task automatic pwr(input logic [7:0] d);
        wr(ADDR_WRITE_KEY, WRITE_KEY_VALUE);
        wr(ADDR_POWER_CONTROL, d);
    endtask : pwr

    task automatic wait_main(input logic exp, output int cnt);
        cnt = 0;
        while (on_main !== exp && cnt < 1000) begin
            @(negedge i_mclk);
            cnt++;
        end
    endtask : wait_main

    task automatic count_en(input int w, output int cnt);
        cnt = 0;
        repeat (w) begin
            @(posedge i_mclk);
            #1;
            if (core_en === 1'b1) cnt++;
        end
    endtask : count_en

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // watchdog: divider sweep dominates, about 63k cycles
    initial begin
        repeat (80000) @(posedge i_mclk);
        n_errors++;
        conclude();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (10) @(negedge i_mclk);
        i_rst_n = 1'b1;
        rd_chk(ADDR_POWER_CONTROL, 8'h82);
        rd_chk(ADDR_DEVICE_CONFIG, 8'h60);
        rd_chk(ADDR_EVENT_FLAG, 8'h00);
        check(8'(irq), 8'h00);
        $display("test reset done");

        wr(ADDR_POWER_CONTROL, 8'h40);
        rd_chk(ADDR_POWER_CONTROL, 8'h82);
        pwr(8'h41);
        rd_chk(ADDR_POWER_CONTROL, 8'hC1);
        check(8'({meter_off, adc_ok}), 8'h02);
        wr(ADDR_POWER_CONTROL, 8'h02);
        rd_chk(ADDR_POWER_CONTROL, 8'hC1);
        wr(ADDR_WRITE_KEY, WRITE_KEY_VALUE);
        wr(8'h00, 8'h55);
        wr(ADDR_POWER_CONTROL, 8'h02);
        rd_chk(ADDR_POWER_CONTROL, 8'hC1);
        rd_chk(8'h00, 8'h00);
        $display("test key done");

        // 7812 cycles hold 256 base-rate pulses at 125 MHz
        for (int sel = 0; sel < 8; sel++) begin
            pwr(8'(sel));
            count_en(7812, n);
            check_range(n, (256 >> sel) - 1, (256 >> sel) + 1);
        end
        pwr(8'h02);
        $display("test divider done");

        wr(ADDR_EVENT_ENABLE, 8'h82);
        vdd = 1'b0;
        wait_main(1'b0, n);
        check_range(n, 1, 3);
        rd_chk(ADDR_DEVICE_CONFIG, 8'h00);
        check(8'({adc_ok, core_run, irq}), 8'h02);
        rd_chk(ADDR_EVENT_FLAG, 8'h02);
        wr(ADDR_IRQ_EN_PRIO2, 8'h02);
        check(8'(irq), 8'h01);
        pwr(8'h12);
        check(8'({deep, core_run}), 8'h02);
        vdd = 1'b1;
        wait_main(1'b1, n);
        check_range(n, RD, RD + 4);
        check(8'({deep, core_run, adc_ok}), 8'h03);
        pwr(8'h12);
        check(8'({deep, core_run}), 8'h01);
        pwr(8'h02);
        rd_chk(ADDR_EVENT_FLAG, 8'h82);
        wr(ADDR_EVENT_FLAG, 8'h00);
        rd_chk(ADDR_EVENT_FLAG, 8'h00);
        check(8'(irq), 8'h00);
        wr(ADDR_EVENT_ENABLE, 8'h80);
        vdd = 1'b0;
        wait_main(1'b0, n);
        check(8'(irq), 8'h00);
        vdd = 1'b1;
        wait_main(1'b1, n);
        check(8'(irq), 8'h01);
        wr(ADDR_EVENT_FLAG, 8'h00);
        $display("test main supply done");

        for (int v = 2; v < 4; v++) begin
            wr(ADDR_SWITCH_CONFIG, 8'(v));
            vdd = 1'b0;
            repeat (10) @(negedge i_mclk);
            check(8'(on_main), 8'h01);
            vdd = 1'b1;
            repeat (2) @(negedge i_mclk);
        end
        wr(ADDR_SWITCH_CONFIG, 8'h00);
        dcin = 1'b0;
        repeat (DD + 10) @(negedge i_mclk);
        check(8'(on_main), 8'h01);
        dcin = 1'b1;
        wr(ADDR_SWITCH_CONFIG, 8'h01);
        dcin = 1'b0;
        wait_main(1'b0, n);
        check_range(n, DD + 1, DD + 4);
        repeat (RD + 10) @(negedge i_mclk);
        check(8'(on_main), 8'h00);
        dcin = 1'b1;
        wait_main(1'b1, n);
        check_range(n, RD, RD + 4);
        wr(ADDR_SWITCH_CONFIG, 8'h00);
        $display("test dc input done");

        pin = 1'b0;
        repeat (5) @(negedge i_mclk);
        check(8'(on_main), 8'h01);
        pin = 1'b1;
        wr(ADDR_INT_PIN_CFG, 8'h10);
        pin = 1'b0;
        wait_main(1'b0, n);
        check_range(n, 1, 3);
        repeat (RD + 10) @(negedge i_mclk);
        check(8'(on_main), 8'h00);
        pin = 1'b1;
        wait_main(1'b1, n);
        check_range(n, RD, RD + 4);
        $display("test control pin done");
        conclude();
    end
endmodule : power_control_battery_switchover_tb
`default_nettype wire
